// ==== gpm_top.sv ====
// pin mode configuration with forced functions, alternate routing, boot select and axi4-lite registers
`timescale 1ns/100ps
`include "gpm_map.svh"
module gpm_top
  import gpm_pkg::*;
#(
  parameter int NPINS       = 24,
  parameter int RC_DIV      = `GPM_RC_PERIOD_NS / `GPM_CLK_PERIOD_NS,
  parameter int BOOT_PERIODS = `GPM_BOOT_RC_PERIODS
) (
  input  wire logic              clk,
  input  wire logic              reset,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // package pins
  input  wire logic [NPINS-1:0]  pad_in,
  output logic [NPINS-1:0]       pad_out,
  output logic [NPINS-1:0]       pad_oe_n,
  output logic [NPINS-1:0]       pad_pull_up,
  output logic [NPINS-1:0]       pad_pull_down,
  output logic [NPINS-1:0]       periph_in,
  // alternate sources
  input  wire logic [3:0]        timer_channel_out,
  input  wire logic [7:0]        timer_route_option,
  input  wire logic [3:0]        timer_output_enable_reg,
  input  wire logic [NPINS-1:0]  serial_ctrl_out,
  input  wire logic [NPINS-1:0]  serial_ctrl_mode_en,
  input  wire logic              packet_trace_enable,
  input  wire logic              packet_trace_data,
  input  wire logic              cpu_trace_bit_two,
  input  wire logic              cpu_trace_bit_three,
  // debugger and system
  input  wire logic              dbg_jtag_active,
  input  wire logic              dbg_sw_active,
  input  wire logic              test_data_out,
  input  wire logic              swdio_out,
  input  wire logic              swdio_drive,
  input  wire logic              ext_regulator_enable,
  input  wire logic              boot_reset_cause,
  output logic                   boot_select_n_out,
  output logic                   boot_busy
);
  localparam int CW = $clog2(RC_DIV + 1);
  localparam int PW = $clog2(BOOT_PERIODS + 1);

  // configuration and state registers
  logic [3:0]       mode_r [NPINS];
  logic [NPINS-1:0] pin_output_level_r;
  logic [2:0]       debug_config_reg_r;
  logic             boot_select_capture_r;
  gpm_boot_t        boot_r, boot_nxt;
  logic [CW-1:0]    rc_cnt_r;
  logic [PW-1:0]    per_cnt_r;

  // bus holding registers
  logic             aw_hold_r, w_hold_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             bvalid_r, rvalid_r;
  logic [1:0]       bresp_r, rresp_r;
  logic [31:0]      rdata_r;

  // ---------------- write path ----------------
  // address and data are latched separately so they may arrive in any order
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  wire   do_write      = aw_hold_r && w_hold_r && !bvalid_r;
  wire [5:0] w_idx     = aw_addr_r[7:2];
  wire   w_cfg         = do_write && (aw_addr_r <= `GPM_CFGH_C_OFS);
  wire   w_out         = do_write && (aw_addr_r >= `GPM_OUT_A_OFS) && (aw_addr_r <= `GPM_OUT_C_OFS);
  wire   w_ro          = (aw_addr_r >= `GPM_IN_A_OFS) && (aw_addr_r <= `GPM_IN_C_OFS)
                         || (aw_addr_r == `GPM_DBGSTAT_OFS);
  wire   w_dbg         = do_write && (aw_addr_r == `GPM_DBGCFG_OFS);
  wire   w_ok          = (aw_addr_r[1:0] == 2'h0) && (w_cfg || w_out || w_dbg || w_ro);
  wire [1:0] out_port  = 2'(w_idx - 6'(`GPM_OUT_A_OFS >> 2));
  wire [31:0] w_mask   = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // catch the address and data halves of a write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response; unmapped or misaligned writes answer slverr and store nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `GPM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_ok ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // mode codes: word idx 2p is pins 3..0 of port p, 2p+1 is pins 7..4
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_cfg
      localparam int WIDX = (g / 8) * 2 + ((g % 8) / 4);            // word holding this pin
      localparam int FLSB = (g % 4) * 4;                              // field inside the word
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          mode_r[g] <= `GPM_MODE_IN_FLOAT;
        end else if (w_cfg && (w_idx == 6'(WIDX)) && w_ok && w_mask[FLSB]) begin
          mode_r[g] <= w_data_r[FLSB +: 4];
        end
      end
    end
  endgenerate

  // output-level bits and debug configuration
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_output_level_r <= '0;
      debug_config_reg_r <= `GPM_DBGCFG_RST;
    end else begin
      if (w_out && w_ok && w_strb_r[0]) begin
        pin_output_level_r[out_port*8 +: 8] <= w_data_r[7:0];
      end
      if (w_dbg && w_ok && w_strb_r[0]) begin
        debug_config_reg_r <= w_data_r[2:0];
      end
    end
  end

  // ---------------- read path ----------------
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [NPINS-1:0] pin_input_level;
  wire [5:0] r_idx = s_axi_araddr[7:2];
  assign s_axi_arready = !rvalid_r;

  // read decode; input words show the live pin level, analog pins read 1 unless a forced function holds them
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = (s_axi_araddr[1:0] == 2'h0);
    if (s_axi_araddr <= `GPM_CFGH_C_OFS) begin
      for (int i = 0; i < 4; i++) begin
        rd_word[i*4 +: 4] = mode_r[r_idx*4 + i];
      end
    end else if (s_axi_araddr <= `GPM_OUT_C_OFS) begin
      rd_word[7:0] = pin_output_level_r[2'(r_idx - 6'(`GPM_OUT_A_OFS >> 2))*8 +: 8];
    end else if (s_axi_araddr <= `GPM_IN_C_OFS) begin
      rd_word[7:0] = pin_input_level[2'(r_idx - 6'(`GPM_IN_A_OFS >> 2))*8 +: 8];
    end else if (s_axi_araddr == `GPM_DBGCFG_OFS) begin
      rd_word[2:0] = debug_config_reg_r;
    end else if (s_axi_araddr == `GPM_DBGSTAT_OFS) begin
      rd_word[`GPM_DBGSTAT_BOOT_BIT] = boot_select_capture_r;
      rd_word[`GPM_DBGSTAT_SW_BIT]   = dbg_sw_active;
      rd_word[`GPM_DBGSTAT_JTAG_BIT] = dbg_jtag_active;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read data register, held until rready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `GPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_ok ? rd_word : 32'h0000_0000;
      rresp_r  <= rd_ok ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ---------------- alternate output source ----------------
  logic [NPINS-1:0] tim_hit, tim_val, alt_val;
  localparam logic [4:0] TIM_PIN_A [4] = '{5'h00, 5'h03, 5'h01, 5'h02};
  localparam logic [4:0] TIM_PIN_B [4] = '{5'h09, 5'h0A, 5'h0B, 5'h0C};

  // enabled timer channels land on the pin their option bit picks
  always_comb begin
    tim_hit = '0;
    tim_val = '0;
    for (int c = 0; c < 4; c++) begin
      if (timer_output_enable_reg[c]) begin
        if (timer_route_option[`GPM_TIM_OPT_LSB + c]) begin
          tim_hit[TIM_PIN_B[c]] = 1'b1;
          tim_val[TIM_PIN_B[c]] = timer_channel_out[c];
        end else begin
          tim_hit[TIM_PIN_A[c]] = 1'b1;
          tim_val[TIM_PIN_A[c]] = timer_channel_out[c];
        end
      end
    end
  end

  // per-pin source: trace on PA4/PA5, else timer over serial, else 0
  wire trace_cpu = debug_config_reg_r[`GPM_DBGCFG_TRC_BIT];
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      if (tim_hit[p]) begin
        alt_val[p] = tim_val[p];
      end else if (serial_ctrl_mode_en[p]) begin
        alt_val[p] = serial_ctrl_out[p];
      end else begin
        alt_val[p] = 1'b0;
      end
    end
    alt_val[`GPM_PIN_PA4] = trace_cpu ? cpu_trace_bit_two : packet_trace_enable;
    alt_val[`GPM_PIN_PA5] = trace_cpu ? cpu_trace_bit_three : packet_trace_data;
  end

  // ---------------- forced functions ----------------
  logic [NPINS-1:0] force_en;
  gpm_pad_t         force_pad [NPINS];
  wire dbg_on   = !debug_config_reg_r[`GPM_DBGCFG_DIS_BIT];
  wire jtag_on  = dbg_on && dbg_jtag_active;
  wire sw_on    = dbg_on && dbg_sw_active;
  wire ext_on   = debug_config_reg_r[`GPM_DBGCFG_EXT_BIT];

  // override table; anything not listed follows its mode code
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      force_en[p]  = 1'b0;
      force_pad[p] = '{val: 1'b0, oe_n: 1'b1, pu: 1'b0, pd: 1'b0};
    end
    if (ext_on) begin
      force_en[`GPM_PIN_PA7]  = 1'b1;
      force_pad[`GPM_PIN_PA7] = '{val: 1'b0, oe_n: ext_regulator_enable, pu: 1'b0, pd: 1'b0};
    end
    if (boot_busy) begin
      force_en[`GPM_PIN_PA5]  = 1'b1;
      force_pad[`GPM_PIN_PA5] = '{val: 1'b0, oe_n: 1'b1, pu: 1'b1, pd: 1'b0};
    end
    if (jtag_on) begin
      force_en[`GPM_PIN_PC0]  = 1'b1;
      force_pad[`GPM_PIN_PC0] = '{val: 1'b0, oe_n: 1'b1, pu: 1'b1, pd: 1'b0};
      force_en[`GPM_PIN_PC2]  = 1'b1;
      force_pad[`GPM_PIN_PC2] = '{val: test_data_out, oe_n: 1'b0, pu: 1'b0, pd: 1'b0};
      force_en[`GPM_PIN_PC3]  = 1'b1;
      force_pad[`GPM_PIN_PC3] = '{val: 1'b0, oe_n: 1'b1, pu: 1'b1, pd: 1'b0};
      force_en[`GPM_PIN_PC4]  = 1'b1;
      force_pad[`GPM_PIN_PC4] = '{val: 1'b0, oe_n: 1'b1, pu: 1'b1, pd: 1'b0};
    end else if (sw_on) begin
      force_en[`GPM_PIN_PC4]  = 1'b1;
      force_pad[`GPM_PIN_PC4] = '{val: swdio_out, oe_n: !swdio_drive, pu: 1'b0, pd: 1'b0};
    end
  end

  // ---------------- boot select window ----------------
  // the cause is looked at after release, since an async reset may only load constants
  wire rc_tick = (rc_cnt_r == CW'(RC_DIV - 1));
  always_comb begin
    boot_nxt = boot_r;
    unique case (boot_r)
      GPM_BOOT_START: boot_nxt = boot_reset_cause ? GPM_BOOT_HOLD : GPM_BOOT_DONE;
      GPM_BOOT_HOLD:  if (rc_tick && per_cnt_r == PW'(BOOT_PERIODS - 1)) boot_nxt = GPM_BOOT_DONE;
      GPM_BOOT_DONE:  boot_nxt = GPM_BOOT_DONE;
    endcase
  end
  assign boot_busy = (boot_r != GPM_BOOT_DONE);

  // rc period divider and window counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_r    <= GPM_BOOT_START;
      rc_cnt_r  <= '0;
      per_cnt_r <= '0;
    end else begin
      boot_r    <= boot_nxt;
      rc_cnt_r  <= (rc_tick || boot_r != GPM_BOOT_HOLD) ? '0 : rc_cnt_r + 1'b1;
      per_cnt_r <= (boot_r != GPM_BOOT_HOLD) ? '0 : per_cnt_r + PW'(rc_tick);
    end
  end

  // sample at the end of the window; other resets keep the reset value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_select_capture_r <= `GPM_BOOT_RST;
    end else if (boot_r == GPM_BOOT_HOLD && boot_nxt == GPM_BOOT_DONE) begin
      boot_select_capture_r <= pad_in[`GPM_PIN_PA5];
    end
  end
  assign boot_select_n_out = boot_select_capture_r;

  // ---------------- pin cells ----------------
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      gpm_pad_t pad;
      gpm_pin u_pin (
        .mode      (mode_r[g]),
        .sw_out    (pin_output_level_r[g]),
        .alt_out   (alt_val[g]),
        .force_en  (force_en[g]),
        .force_pad (force_pad[g]),
        .pin_level (pad_in[g]),
        .pad       (pad),
        .rd_level  (pin_input_level[g])
      );
      assign pad_out[g]       = pad.val;
      assign pad_oe_n[g]      = pad.oe_n;
      assign pad_pull_up[g]   = pad.pu;
      assign pad_pull_down[g] = pad.pd;
      assign periph_in[g]     = pin_input_level[g];
    end
  endgenerate
endmodule : gpm_top

// ==== gpm_map.svh ====
// register offsets, field positions, mode codes, reset values and timing for the pin mode block
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH
// byte offsets of the register words
`define GPM_CFGL_A_OFS      8'h00
`define GPM_CFGH_C_OFS      8'h14
`define GPM_OUT_A_OFS       8'h18
`define GPM_OUT_C_OFS       8'h20
`define GPM_IN_A_OFS        8'h24
`define GPM_IN_C_OFS        8'h2C
`define GPM_DBGCFG_OFS      8'h30
`define GPM_DBGSTAT_OFS     8'h34
// debug config fields
`define GPM_DBGCFG_DIS_BIT  0
`define GPM_DBGCFG_EXT_BIT  1
`define GPM_DBGCFG_TRC_BIT  2
`define GPM_DBGCFG_RST      3'h2
// debug status fields
`define GPM_DBGSTAT_BOOT_BIT 0
`define GPM_DBGSTAT_SW_BIT   1
`define GPM_DBGSTAT_JTAG_BIT 2
`define GPM_BOOT_RST        1'h1
// mode codes
`define GPM_MODE_ANALOG     4'h0
`define GPM_MODE_OUT_PP     4'h1
`define GPM_MODE_IN_FLOAT   4'h4
`define GPM_MODE_OUT_OD     4'h5
`define GPM_MODE_IN_PULL    4'h8
`define GPM_MODE_ALT_PP     4'h9
`define GPM_MODE_ALT_SCLK   4'hB
`define GPM_MODE_ALT_OD     4'hD
// pin indexes: port a 0..7, port b 8..15, port c 16..23
`define GPM_PIN_PA4         4
`define GPM_PIN_PA5         5
`define GPM_PIN_PA7         7
`define GPM_PIN_PC0         16
`define GPM_PIN_PC2         18
`define GPM_PIN_PC3         19
`define GPM_PIN_PC4         20
`define GPM_TIM_OPT_LSB     4
// boot window timing
`define GPM_CLK_PERIOD_NS   4
`define GPM_RC_PERIOD_NS    83
`define GPM_BOOT_RC_PERIODS 512
// axi responses
`define GPM_RESP_OKAY       2'h0
`define GPM_RESP_SLVERR     2'h2
`endif

// ==== gpm_pkg.sv ====
// types shared by the pin mode block
package gpm_pkg;
  // drive seen by one package pin
  typedef struct packed {
    logic val;    // level driven when enabled
    logic oe_n;   // low while the pin is driven
    logic pu;     // pull-up on
    logic pd;     // pull-down on
  } gpm_pad_t;

  typedef enum logic [1:0] {
    GPM_BOOT_START,
    GPM_BOOT_HOLD,
    GPM_BOOT_DONE
  } gpm_boot_t;
endpackage : gpm_pkg

// ==== gpm_pin.sv ====
// one pin: mode decode into pad drive and input read value
`timescale 1ns/100ps
`include "gpm_map.svh"
module gpm_pin
  import gpm_pkg::*;
(
  input  wire logic [3:0] mode,
  input  wire logic       sw_out,
  input  wire logic       alt_out,
  input  wire logic       force_en,
  input  wire gpm_pad_t   force_pad,
  input  wire logic       pin_level,
  output gpm_pad_t        pad,
  output logic            rd_level
);
  gpm_pad_t mode_pad;
  wire is_analog = (mode == `GPM_MODE_ANALOG) && !force_en;

  // decode the mode code; an unknown code parks the pin as a floating input
  always_comb begin
    mode_pad = '{val: 1'b0, oe_n: 1'b1, pu: 1'b0, pd: 1'b0};
    case (mode)
      `GPM_MODE_ANALOG:   mode_pad.oe_n = 1'b1;
      `GPM_MODE_IN_FLOAT: mode_pad.oe_n = 1'b1;
      `GPM_MODE_IN_PULL: begin
        mode_pad.pu = sw_out;
        mode_pad.pd = !sw_out;
      end
      `GPM_MODE_OUT_PP: begin
        mode_pad.val  = sw_out;
        mode_pad.oe_n = 1'b0;
      end
      `GPM_MODE_OUT_OD: mode_pad.oe_n = sw_out;
      `GPM_MODE_ALT_PP, `GPM_MODE_ALT_SCLK: begin
        mode_pad.val  = alt_out;
        mode_pad.oe_n = 1'b0;
      end
      `GPM_MODE_ALT_OD: mode_pad.oe_n = alt_out;
      default:          mode_pad.oe_n = 1'b1;
    endcase
  end

  // forced functions win over the mode code
  assign pad      = force_en ? force_pad : mode_pad;
  // analog ties the schmitt input high unless a forced function holds the pin, every other mode sees the pin
  assign rd_level = is_analog ? 1'b1 : pin_level;
endmodule : gpm_pin

// ==== gpm_asserts.sv ====
// port-level checks for the pin mode block
`timescale 1ns/100ps
module gpm_asserts #(
  parameter int RC_DIV       = 20,
  parameter int BOOT_PERIODS = 512
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [23:0] pad_in,
  input wire logic [23:0] pad_oe_n,
  input wire logic [23:0] pad_pull_up,
  input wire logic [23:0] pad_pull_down,
  input wire logic [23:0] periph_in,
  input wire logic        boot_busy,
  input wire logic        boot_select_n_out
);
  localparam int BOOT_LEN = RC_DIV * BOOT_PERIODS;
  int boot_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // boot window length; a counter because the window is far beyond a repetition
  always_ff @(posedge clk or posedge reset)
    if (reset) boot_cnt_r <= 0;
    else if (boot_busy) boot_cnt_r <= boot_cnt_r + 1;
  a_drive_no_pull: assert property ((~pad_oe_n & (pad_pull_up | pad_pull_down)) == 24'h0)
    else $error("pull on while pin driven");
  a_pull_one_side: assert property ((pad_pull_up & pad_pull_down) == 24'h0)
    else $error("both pulls on");
  a_periph_level: assert property ((pad_in & ~periph_in) == 24'h0)
    else $error("peripheral level lost a high pin");
  a_boot_pullup: assert property (boot_busy |-> pad_pull_up[5] && pad_oe_n[5])
    else $error("boot pin not pulled up");
  a_boot_bounded: assert property (boot_cnt_r <= BOOT_LEN + 2)
    else $error("boot window too long");
  a_boot_kept: assert property (!boot_busy && !$past(boot_busy) && !$past(boot_busy, 2)
    |-> $stable(boot_select_n_out)) else $error("boot capture changed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : gpm_asserts
bind gpm_top gpm_asserts #(.RC_DIV(RC_DIV), .BOOT_PERIODS(BOOT_PERIODS)) u_chk (.clk, .reset, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pad_in, .pad_oe_n, .pad_pull_up, .pad_pull_down,
  .periph_in, .boot_busy, .boot_select_n_out);

// ==== gpm_board.sv ====
// board model: levels seen on the package pins
`timescale 1ns/100ps
module gpm_board (
  input wire logic        clk,
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe_n,
  input wire logic [23:0] pad_pull_up,
  input wire logic [23:0] pad_pull_down,
  input wire logic [23:0] ext_drv,
  input wire logic [23:0] ext_val,
  output logic [23:0]     pad_in
);
  logic [23:0] wander_r = 24'h5A5A5A;
  // a pin nobody drives or pulls changes every cycle, so stale levels never pass
  always_ff @(posedge clk) wander_r <= ~wander_r;
  // chip drive wins over the board source, which wins over the pulls
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_drv & ext_val)
                | (pad_oe_n & ~ext_drv & (pad_pull_up | (~pad_pull_down & wander_r)));
endmodule : gpm_board

// ==== testbench.sv ====
// self-checking bench for the pin mode block
`timescale 1ns/100ps
module testbench;
  import gpm_pkg::*;
  localparam int RCD = 2;
  localparam int BPN = 4;
  logic        clk = 1'h0, reset = 1'h1, o, t;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, timer_route_option = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0]  s_axi_wstrb = 4'hF, timer_channel_out = 4'h0, timer_output_enable_reg = 4'h0, m, pg;
  logic [23:0] serial_ctrl_out = 24'h0, serial_ctrl_mode_en = 24'h0, ext_drv = 24'h004020, ext_val = 24'h0;
  logic        dbg_jtag_active = 1'h0, dbg_sw_active = 1'h0, test_data_out = 1'h0, swdio_out = 1'h0;
  logic        swdio_drive = 1'h0, ext_regulator_enable = 1'h0, boot_reset_cause = 1'h0;
  logic        packet_trace_enable = 1'h0, packet_trace_data = 1'h0;
  logic        cpu_trace_bit_two = 1'h0, cpu_trace_bit_three = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, boot_select_n_out, boot_busy;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic [23:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down, periph_in;
  logic [4:0]  e5;
  logic [3:0]  modes [8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hB, 4'hD};
  int          failures = 0, checked = 0;
  gpm_top #(.RC_DIV(RCD), .BOOT_PERIODS(BPN)) i_dut (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up,
    .pad_pull_down, .periph_in, .timer_channel_out, .timer_route_option, .timer_output_enable_reg,
    .serial_ctrl_out, .serial_ctrl_mode_en, .packet_trace_enable, .packet_trace_data,
    .cpu_trace_bit_two, .cpu_trace_bit_three, .dbg_jtag_active, .dbg_sw_active, .test_data_out,
    .swdio_out, .swdio_drive, .ext_regulator_enable, .boot_reset_cause, .boot_select_n_out, .boot_busy);
  gpm_board i_board (.clk, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .ext_drv, .ext_val, .pad_in);
  always #2 clk = ~clk;
  // expected {oe_n, driven level, pull up, pull down, read level} of the probe pin
  function automatic logic [4:0] pin_exp(input logic [3:0] md, input logic ov, a, e);
    case (md)
      4'h0: return 5'h11;
      4'h4: return {4'h8, e};
      4'h8: return {2'h2, ov, !ov, e};
      4'h1: return {1'h0, ov, 2'h0, ov};
      4'h5: return {ov, 3'h0, ov & e};
      4'hD: return {a, 3'h0, a & e};
      default: return {1'h0, a, 2'h0, a};
    endcase
  endfunction : pin_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // one write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic summarize;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // the tests need a few hundred cycles; this span leaves a wide margin
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(32715));
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    ext_regulator_enable <= 1'($urandom);
    settle();
    chk(pad_oe_n[7], ext_regulator_enable);
    chk(boot_select_n_out, 1'h1);
    // four pins of four bits each fill only the low half of a config word
    for (int a = 0; a < 24; a += 4) begin
      rd(8'(a), d, r);
      chk(d, 32'h0000_4444);
    end
    rd(8'h30, d, r);
    chk(d[2:0], 3'h2);
    $display("reset test done");
    // every mode code on one pin with random level, peripheral and board values
    for (int i = 0; i < 16; i++) begin
      m = modes[i % 8];
      o = 1'($urandom);
      @(posedge clk);
      ext_val[14] <= 1'($urandom);
      serial_ctrl_mode_en[14] <= 1'($urandom);
      serial_ctrl_out[14] <= 1'($urandom);
      wr(8'h1C, 32'(o) << 6, r);
      wr(8'h0C, 32'h0000_4044 | (32'(m) << 8), r);
      settle();
      rd(8'h28, d, r);
      e5 = pin_exp(m, o, serial_ctrl_mode_en[14] & serial_ctrl_out[14], ext_val[14]);
      pg = {pad_oe_n[14], ~pad_oe_n[14] & pad_out[14], pad_pull_up[14], pad_pull_down[14]};
      chk(pg, e5[4:1]);
      chk({d[6], periph_in[14]}, {2{e5[0]}});
    end
    $display("mode test done");
    t = 1'($urandom);
    @(posedge clk);
    timer_route_option <= 8'h10;
    timer_output_enable_reg <= 4'h1;
    timer_channel_out <= {3'h0, t};
    serial_ctrl_mode_en[9] <= 1'h1;
    serial_ctrl_out[9] <= !t;
    wr(8'h08, 32'h4444_4494, r);
    settle();
    chk(pad_out[9], t);
    @(posedge clk);
    timer_route_option <= 8'h00;
    settle();
    chk(pad_out[9], !t);
    // both trace sources on PA4/PA5 with the pins in alternate push-pull
    @(posedge clk);
    packet_trace_enable <= 1'($urandom);
    packet_trace_data <= 1'($urandom);
    cpu_trace_bit_two <= 1'($urandom);
    cpu_trace_bit_three <= 1'($urandom);
    wr(8'h04, 32'h0000_4499, r);
    settle();
    chk(pad_out[5:4], {packet_trace_data, packet_trace_enable});
    wr(8'h30, 32'h0000_0006, r);
    settle();
    chk(pad_out[5:4], {cpu_trace_bit_three, cpu_trace_bit_two});
    $display("routing test done");
    @(posedge clk);
    dbg_jtag_active <= 1'h1;
    test_data_out <= 1'($urandom);
    settle();
    chk({pad_oe_n[18], pad_out[18]}, {1'h0, test_data_out});
    chk({pad_pull_up[16], pad_pull_up[19], pad_pull_up[20]}, 3'h7);
    @(posedge clk);
    dbg_jtag_active <= 1'h0;
    dbg_sw_active <= 1'h1;
    swdio_drive <= 1'($urandom);
    swdio_out <= 1'($urandom);
    settle();
    chk({pad_oe_n[20], ~pad_oe_n[20] & pad_out[20]}, {!swdio_drive, swdio_drive & swdio_out});
    wr(8'h30, 32'h0000_0001, r);
    dbg_jtag_active <= 1'h1;
    settle();
    chk({pad_oe_n[7], pad_oe_n[18], pad_oe_n[20], pad_pull_up[16]}, 4'hE);
    wr(8'h40, 32'hFFFF_FFFF, r);
    chk(r, 2'h2);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    $display("debug test done");
    // pin reset with the boot pin held low by the board
    @(posedge clk);
    reset <= 1'h1;
    boot_reset_cause <= 1'h1;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    for (int k = 0; k < 100 && boot_busy !== 1'h0; k++) @(posedge clk);
    settle();
    chk(boot_busy, 1'h0);
    chk(boot_select_n_out, 1'h0);
    chk(pad_pull_up[5], 1'h0);
    rd(8'h34, d, r);
    chk(d[0], 1'h0);
    chk(d[2:1], {dbg_jtag_active, dbg_sw_active});
    $display("boot test done");
    summarize();
  end
endmodule : testbench
